// file: rtl/lrfsc_pkg.sv
// Package with register map, field layout and the link sample carrier of the receive FIFO block.
package lrfsc_pkg;

  // Register offsets on the plain register port.
  localparam logic [7:0] ADDR_WINDOW = 8'h00;
  localparam logic [7:0] ADDR_RX_CTRL = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h06;
  localparam logic [7:0] ADDR_FIFO_CTRL = 8'h08;
  localparam logic [7:0] ADDR_FILL = 8'h0A;
  localparam logic [7:0] ADDR_LINE_CODES = 8'h0C;
  localparam logic [7:0] ADDR_FRAME_CODES = 8'h0E;
  localparam logic [7:0] ADDR_LINE_TALLY = 8'h10;
  localparam logic [7:0] ADDR_DU_TALLY = 8'h12;

  // Field positions.
  localparam int BIT_RECEIVE_ENABLE = 0;
  localparam int BIT_END_CODE_CHECK = 3;
  localparam int BIT_LEVEL_REQ_ENABLE = 10;
  localparam int BIT_OVERRUN = 0;
  localparam int BIT_UNDERRUN = 1;
  localparam int BIT_LEVEL = 2;
  localparam int BIT_FLUSH = 0;
  localparam int TRIG_LSB = 4;
  localparam int TRIG_MSB = 6;
  localparam int FILL_MSB = 4;
  localparam int START_CODE_LSB = 8;
  localparam int START_CODE_MSB = 15;
  localparam int END_CODE_MSB = 7;

  // Reset values.
  localparam logic [2:0] TRIG_RESET = 3'h7;
  localparam logic [15:0] CODES_RESET = 16'h0000;
  localparam logic [15:0] TALLY_RESET = 16'h0000;

  // Receive FIFO geometry.
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_AW = 4;
  localparam int WORD_W = 32;
  localparam int CODE_W = 8;

  // One sample of the deserialiser pins, moved across the clock boundary as a whole.
  typedef struct packed {
    logic link_clk;
    logic word_stb;
    logic code_stb;
    logic [WORD_W-1:0] word;
    logic [CODE_W-1:0] code;
  } lrfsc_link_t;

endpackage

// file: rtl/lrfsc_sync.sv
// Two-stage synchroniser for the link sample bundle.
`timescale 1ns/1ps
module lrfsc_sync
  import lrfsc_pkg::*;
#(
  parameter int W = $bits(lrfsc_link_t)
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  // The first stage feeds only the second stage, never any logic.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

// file: rtl/lrfsc_mem.sv
// Sixteen-entry receive FIFO storage with registered read data.
`timescale 1ns/1ps
module lrfsc_mem
  import lrfsc_pkg::*;
#(
  parameter int DW = WORD_W,
  parameter int AW = FIFO_AW
) (
  input wire logic mclk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic re,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);

  logic [DW-1:0] mem_q [0:(1<<AW)-1];

  // Storage holds no reset; the fill count alone says which entries are valid.
  always_ff @(posedge mclk) begin
    if (we) begin
      mem_q[waddr] <= wdata;
    end
    // A word written to the address being read passes straight through, so the head is never stale.
    if (re) begin
      rdata <= (we && waddr == raddr) ? wdata : mem_q[raddr];
    end
  end

endmodule

// file: rtl/lrfsc_top.sv
// Receive FIFO, status flags, control codes and line and data-unit tallies of the serial receiver.
// Functional notes
// - Level flag sets when fill reaches trigger.
// - Software clears level flag after draining.
// - DMA completion below trigger clears level flag.
// - Controller completion, requests enabled, clears flag.
// - Reset clears flags, FIFO, fill, tallies.
// - Reading empty window sets underrun flag.
// - Seventeenth stored word sets overrun flag.
// - Overrun keeps data, refuses new words.
// - Flags clear by zero after reading one.
// - Trigger code n selects 2n entries.
// - Flush empties FIFO, bit returns to zero.
// - Fill level readable as five bits.
// - Four programmable eight-bit control codes.
// - Line tally updates at frame end.
// - Lines count from reception start without frame start.
// - Data-unit tally updates at each end code.
// - Tallies meaningful only with end-code checking.
// - Control codes matched against four values.
// - Level request follows flag and enable.
// - Window word holds channel 0 high, 1 low.
//
// Local design decisions: the register offsets and the strobed register port.
`timescale 1ns/1ps
module lrfsc_top
  import lrfsc_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic link_clk,
  input wire logic link_word_stb,
  input wire logic [31:0] link_word,
  input wire logic link_code_stb,
  input wire logic [7:0] link_code,
  input wire logic dma_done,
  input wire logic xfer_done,
  input wire logic xfer_request_disable,
  output logic level_reached_request
);

  // Link side sampling.
  lrfsc_link_t link_raw;
  lrfsc_link_t link_s;
  logic link_clk_prev_q;

  assign link_raw = '{link_clk: link_clk, word_stb: link_word_stb, code_stb: link_code_stb,
                      word: link_word, code: link_code};

  lrfsc_sync u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .async_in(link_raw),
    .sync_out(link_s)
  );

  // Data and strobes are sampled on the rising edge of the synchronised link clock.
  // The deserialiser holds them for a whole link period, so they are settled by then.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      link_clk_prev_q <= 1'b0;
    end else begin
      link_clk_prev_q <= link_s.link_clk;
    end
  end

  wire link_rise = link_s.link_clk && !link_clk_prev_q;
  wire word_evt = link_rise && link_s.word_stb;
  wire code_evt = link_rise && link_s.code_stb;

  // Software registers.
  logic receive_enable_q, end_code_check_q, level_request_enable_q;
  logic [2:0] trig_code_q;
  logic flush_q;
  logic [15:0] line_code_values_q, frame_code_values_q;
  logic [15:0] line_tally_q, data_unit_tally_q;
  logic [15:0] line_cnt_q, du_cnt_q;
  logic in_data_q;
  logic re_prev_q;
  wire [2:0] flag_q, armed_q;
  logic [FIFO_AW-1:0] wr_ptr_q, rd_ptr_q;
  logic [FILL_MSB:0] count_q, count_d;
  logic [31:0] reg_rdata_q;
  logic [WORD_W-1:0] mem_rdata;

  // Address decode.
  wire sel_window = addr == ADDR_WINDOW;
  wire sel_rx_ctrl = addr == ADDR_RX_CTRL;
  wire sel_status = addr == ADDR_STATUS;
  wire sel_fifo_ctrl = addr == ADDR_FIFO_CTRL;
  wire sel_fill = addr == ADDR_FILL;
  wire sel_line_codes = addr == ADDR_LINE_CODES;
  wire sel_frame_codes = addr == ADDR_FRAME_CODES;
  wire sel_line_tally = addr == ADDR_LINE_TALLY;
  wire sel_du_tally = addr == ADDR_DU_TALLY;

  // Trigger level is twice the code; code 000 is prohibited and would trigger on an empty FIFO.
  wire [FILL_MSB:0] trig_level = {1'b0, trig_code_q, 1'b0};
  wire at_level = count_q >= trig_level;
  wire fifo_full = count_q == DEPTH[FILL_MSB:0];
  wire fifo_empty = count_q == '0;

  // Control code identification against the four programmed values.
  wire is_frame_start = code_evt && link_s.code == frame_code_values_q[START_CODE_MSB:START_CODE_LSB];
  wire is_frame_end = code_evt && link_s.code == frame_code_values_q[END_CODE_MSB:0];
  wire is_line_start = code_evt && link_s.code == line_code_values_q[START_CODE_MSB:START_CODE_LSB];
  wire is_line_end = code_evt && link_s.code == line_code_values_q[END_CODE_MSB:0];
  wire any_start = is_frame_start || is_line_start;
  wire any_end = end_code_check_q && (is_frame_end || is_line_end);
  wire re_rise = receive_enable_q && !re_prev_q;

  // FIFO push and pop; with end-code checking, words after an end code are refused until the next start.
  wire store_try = word_evt && receive_enable_q && (in_data_q || !end_code_check_q);
  wire push = store_try && !flag_q[BIT_OVERRUN] && !fifo_full && !flush_q;
  wire over_evt = store_try && !flag_q[BIT_OVERRUN] && fifo_full;
  wire win_rd = rd && sel_window;
  wire pop = win_rd && !fifo_empty && !flush_q;
  wire under_evt = win_rd && fifo_empty;
  // The storage always reads the entry that will stand at the head in the next cycle.
  wire [FIFO_AW-1:0] rd_ptr_d = flush_q ? '0 : rd_ptr_q + FIFO_AW'(pop);

  lrfsc_mem u_mem (
    .mclk(mclk),
    .we(push),
    .waddr(wr_ptr_q),
    .wdata(link_s.word),
    .re(1'b1),
    .raddr(rd_ptr_d),
    .rdata(mem_rdata)
  );

  // Fill count; a flush wins over a push or pop in the same cycle.
  always_comb begin
    count_d = count_q;
    if (flush_q) begin
      count_d = '0;
    end else if (push && !pop) begin
      count_d = count_q + 5'h01;
    end else if (pop && !push) begin
      count_d = count_q - 5'h01;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= '0;
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      count_q <= count_d;
      wr_ptr_q <= flush_q ? '0 : wr_ptr_q + FIFO_AW'(push);
      rd_ptr_q <= rd_ptr_d;
    end
  end

  // Status flag set and clear terms; a set always beats a clear in the same cycle.
  wire st_wr = wr && sel_status;
  wire auto_clear = (dma_done || (xfer_done && !xfer_request_disable)) && !at_level;
  wire [2:0] flag_set;
  wire [2:0] flag_clr;
  assign flag_set[BIT_OVERRUN] = over_evt;
  assign flag_set[BIT_UNDERRUN] = under_evt;
  assign flag_set[BIT_LEVEL] = at_level;

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_flag
      logic flag_bit_q;
      logic armed_bit_q;
      // A zero written counts only if this flag was read as one since the last status write.
      wire sw_clear = st_wr && !wdata[g] && armed_q[g];
      if (g == BIT_LEVEL) begin : g_lvl
        assign flag_clr[g] = (sw_clear && !at_level) || auto_clear;
      end else begin : g_err
        assign flag_clr[g] = sw_clear;
      end
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          flag_bit_q <= 1'b0;
          armed_bit_q <= 1'b0;
        end else begin
          flag_bit_q <= flag_set[g] || (flag_bit_q && !flag_clr[g]);
          armed_bit_q <= st_wr ? 1'b0 : (armed_bit_q || (rd && sel_status && flag_bit_q));
        end
      end
      assign flag_q[g] = flag_bit_q;
      assign armed_q[g] = armed_bit_q;
    end
  endgenerate

  // Receiver control, FIFO control and code registers.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      receive_enable_q <= 1'b0;
      end_code_check_q <= 1'b0;
      level_request_enable_q <= 1'b0;
      trig_code_q <= TRIG_RESET;
      flush_q <= 1'b0;
      line_code_values_q <= CODES_RESET;
      frame_code_values_q <= CODES_RESET;
      re_prev_q <= 1'b0;
    end else begin
      re_prev_q <= receive_enable_q;
      if (wr && sel_rx_ctrl) begin
        receive_enable_q <= wdata[BIT_RECEIVE_ENABLE];
        end_code_check_q <= wdata[BIT_END_CODE_CHECK];
        level_request_enable_q <= wdata[BIT_LEVEL_REQ_ENABLE];
      end
      if (wr && sel_fifo_ctrl) begin
        trig_code_q <= wdata[TRIG_MSB:TRIG_LSB];
      end
      // The flush bit drops by itself on the same edge that empties the FIFO.
      flush_q <= wr && sel_fifo_ctrl && wdata[BIT_FLUSH];
      if (wr && sel_line_codes) begin
        line_code_values_q <= wdata[15:0];
      end
      if (wr && sel_frame_codes) begin
        frame_code_values_q <= wdata[15:0];
      end
    end
  end

  // Line and data-unit tallies; their values carry no meaning while end-code checking is off.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      line_cnt_q <= '0;
      du_cnt_q <= '0;
      line_tally_q <= TALLY_RESET;
      data_unit_tally_q <= TALLY_RESET;
      in_data_q <= 1'b0;
    end else begin
      if (re_rise || is_frame_start) begin
        line_cnt_q <= '0;
      end else if (any_end) begin
        line_cnt_q <= line_cnt_q + 16'h0001;
      end
      if (re_rise || any_start) begin
        du_cnt_q <= '0;
      end else if (push) begin
        du_cnt_q <= du_cnt_q + 16'h0001;
      end
      if (end_code_check_q && is_frame_end) begin
        line_tally_q <= line_cnt_q + 16'h0001;
      end
      if (any_end) begin
        data_unit_tally_q <= du_cnt_q;
      end
      if (any_start) begin
        in_data_q <= 1'b1;
      end else if (any_end || !receive_enable_q) begin
        in_data_q <= 1'b0;
      end
    end
  end

  // Read data leave through one flop; the window takes the head entry the storage already holds.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_q <= '0;
    end else begin
      reg_rdata_q <= '0;
      if (rd) begin
        unique case (1'b1)
          sel_window: reg_rdata_q <= mem_rdata;
          sel_rx_ctrl: begin
            reg_rdata_q[BIT_RECEIVE_ENABLE] <= receive_enable_q;
            reg_rdata_q[BIT_END_CODE_CHECK] <= end_code_check_q;
            reg_rdata_q[BIT_LEVEL_REQ_ENABLE] <= level_request_enable_q;
          end
          sel_status: reg_rdata_q[2:0] <= flag_q;
          sel_fifo_ctrl: reg_rdata_q[TRIG_MSB:TRIG_LSB] <= trig_code_q;
          sel_fill: reg_rdata_q[FILL_MSB:0] <= count_q;
          sel_line_codes: reg_rdata_q[15:0] <= line_code_values_q;
          sel_frame_codes: reg_rdata_q[15:0] <= frame_code_values_q;
          sel_line_tally: reg_rdata_q[15:0] <= line_tally_q;
          sel_du_tally: reg_rdata_q[15:0] <= data_unit_tally_q;
          default: reg_rdata_q <= '0;
        endcase
      end
    end
  end

  // An underrun read returns whatever the storage holds; the value is undefined by design.
  assign rdata = reg_rdata_q;

  // Level request towards DMA or the transfer controller.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      level_reached_request <= 1'b0;
    end else begin
      level_reached_request <= flag_q[BIT_LEVEL] && level_request_enable_q;
    end
  end

  // Checks.
  AST_LEVEL_SET: assert property (@(posedge mclk) disable iff (!rst_n)
    at_level |=> flag_q[BIT_LEVEL])
    else $error("level flag not set at trigger level");

  AST_LEVEL_SW_CLR: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_wr && !wdata[BIT_LEVEL] && armed_q[BIT_LEVEL] && !at_level) |=> !flag_q[BIT_LEVEL])
    else $error("level flag not cleared by software");

  AST_AUTO_CLR: assert property (@(posedge mclk) disable iff (!rst_n)
    (dma_done && !at_level) |=> !flag_q[BIT_LEVEL])
    else $error("level flag kept after DMA completion");

  AST_UNDERRUN: assert property (@(posedge mclk) disable iff (!rst_n)
    (win_rd && count_q == 5'h00) |=> flag_q[BIT_UNDERRUN] && count_q == 5'($past(push)))
    else $error("underrun not flagged");

  AST_OVERRUN: assert property (@(posedge mclk) disable iff (!rst_n)
    over_evt |=> flag_q[BIT_OVERRUN] && count_q == 5'h10 - 5'($past(pop)))
    else $error("overrun not flagged or data lost");

  AST_REFUSE: assert property (@(posedge mclk) disable iff (!rst_n)
    flag_q[BIT_OVERRUN] |-> !push)
    else $error("word stored during overrun");

  AST_WRITE_ONE: assert property (@(posedge mclk) disable iff (!rst_n)
    (st_wr && wdata[BIT_UNDERRUN] && flag_q[BIT_UNDERRUN]) |=> flag_q[BIT_UNDERRUN])
    else $error("writing one cleared a flag");

  AST_FLUSH: assert property (@(posedge mclk) disable iff (!rst_n)
    (wr && sel_fifo_ctrl && wdata[BIT_FLUSH]) |=> flush_q ##1 (!flush_q && count_q == 5'h00))
    else $error("flush did not empty the FIFO");

  AST_FILL_MAX: assert property (@(posedge mclk) disable iff (!rst_n)
    count_q <= 5'h10)
    else $error("fill count beyond sixteen");

  AST_LINE_TALLY: assert property (@(posedge mclk) disable iff (!rst_n)
    (end_code_check_q && is_frame_end) |=> line_tally_q == $past(line_cnt_q) + 16'h0001)
    else $error("line tally not updated at frame end");

  AST_REQUEST: assert property (@(posedge mclk) disable iff (!rst_n)
    (flag_q[BIT_LEVEL] && level_request_enable_q) |=> level_reached_request)
    else $error("level request missing");

  COV_OVERRUN: cover property (@(posedge mclk) disable iff (!rst_n) over_evt);
  COV_UNDERRUN: cover property (@(posedge mclk) disable iff (!rst_n) under_evt);
  COV_LEVEL_REQ: cover property (@(posedge mclk) disable iff (!rst_n) $rose(level_reached_request));
  COV_FRAME_END: cover property (@(posedge mclk) disable iff (!rst_n) end_code_check_q && is_frame_end);

endmodule

// file: test/lrfsc_tx_model.sv
// Behavioural serial transmitter that drives the deserialiser pins of the receive block.
`timescale 1ns/1ps
module lrfsc_tx_model (
  output logic link_clk,
  output logic word_stb,
  output logic [31:0] word,
  output logic code_stb,
  output logic [7:0] code
);
  // Idle pins at time zero; the link clock stands still between transfers.
  initial begin
    link_clk = 1'b0;
    word_stb = 1'b0;
    word = 32'h0;
    code_stb = 1'b0;
    code = 8'h0;
  end

  // One link period of 160 ns; lines are held 80 ns either side of the rise.
  // Released data lines flip so that a stale value is never mistaken for a new one.
  task automatic xfer(input logic ws, input logic [31:0] w, input logic cs, input logic [7:0] c);
    word_stb = ws;
    word = w;
    code_stb = cs;
    code = c;
    #80 link_clk = 1'b1;
    #80 link_clk = 1'b0;
    word_stb = 1'b0;
    code_stb = 1'b0;
    word = ~w;
    code = ~c;
  endtask
endmodule

// file: test/tb.sv
// Self-checking bench for the receive FIFO, its flags and the line and data-unit tallies.
`timescale 1ns/1ps
module tb;
  import lrfsc_pkg::*;
  localparam logic [31:0] CTRL_RUN = 32'h0000_0401;
  localparam logic [31:0] CTRL_END = 32'h0000_0409;
  logic mclk, rst_n, wr, rd, dma_done, xfer_done, xfer_request_disable, level_reached_request;
  logic [7:0] addr;
  logic [31:0] wdata, rdata;
  logic link_clk, link_word_stb, link_code_stb;
  logic [31:0] link_word;
  logic [7:0] link_code;
  logic [31:0] q[$];
  logic ovr_exp;
  int errors = 0;
  int comparisons = 0;
  logic [39:0] rst_tbl [8] = '{{ADDR_STATUS, 32'h0}, {ADDR_FIFO_CTRL, 32'h70}, {ADDR_FILL, 32'h0},
    {ADDR_LINE_CODES, 32'h0}, {ADDR_FRAME_CODES, 32'h0}, {ADDR_LINE_TALLY, 32'h0},
    {ADDR_DU_TALLY, 32'h0}, {8'h40, 32'h0}};

  lrfsc_top i_dut (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .link_clk(link_clk), .link_word_stb(link_word_stb), .link_word(link_word),
    .link_code_stb(link_code_stb), .link_code(link_code), .dma_done(dma_done),
    .xfer_done(xfer_done), .xfer_request_disable(xfer_request_disable),
    .level_reached_request(level_reached_request));

  lrfsc_tx_model i_tx (.link_clk(link_clk), .word_stb(link_word_stb), .word(link_word),
    .code_stb(link_code_stb), .code(link_code));

  // Trigger code n selects 2n entries.
  function automatic logic [31:0] trig_level(input int t);
    return 32'(2 * t);
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Bus cycles: one-cycle strobes, read data taken in the cycle after the strobe.
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd_reg(a, d);
    check(d, exp);
  endtask

  // The bench queue mirrors what the FIFO should hold; a word at full depth marks an overrun.
  task automatic push(input logic [31:0] w);
    i_tx.xfer(1'b1, w, 1'b0, 8'h00);
    if (q.size() == 16) ovr_exp = 1'b1;
    else if (!ovr_exp) q.push_back(w);
  endtask

  task automatic pop();
    logic [31:0] d;
    rd_reg(ADDR_WINDOW, d);
    check(d, q.pop_front());
  endtask

  task automatic send_code(input logic [7:0] c);
    i_tx.xfer(1'b0, $urandom, 1'b1, c);
  endtask

  // Reception is stopped around every control change, then flags are cleared on an empty FIFO.
  task automatic set_fifo(input logic [2:0] t, input logic [31:0] ctrl);
    logic [31:0] d;
    wr_reg(ADDR_RX_CTRL, 32'h0);
    wr_reg(ADDR_FIFO_CTRL, {25'h0, t, 4'h1});
    rd_reg(ADDR_STATUS, d);
    wr_reg(ADDR_STATUS, 32'h0);
    wr_reg(ADDR_RX_CTRL, ctrl);
    q.delete();
    ovr_exp = 1'b0;
  endtask

  task automatic pulse(input logic dma, input logic dis);
    @(posedge mclk);
    dma_done <= dma;
    xfer_done <= !dma;
    xfer_request_disable <= dis;
    @(posedge mclk);
    dma_done <= 1'b0;
    xfer_done <= 1'b0;
  endtask

  task automatic close_out();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // 100 MHz clock.
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Watchdog sized well above the few thousand cycles the tests need.
  initial begin
    repeat (40000) @(posedge mclk);
    errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    close_out();
  end

  // Main sequence.
  initial begin
    logic [31:0] d;
    rst_n = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    dma_done = 1'b0;
    xfer_done = 1'b0;
    xfer_request_disable = 1'b0;
    ovr_exp = 1'b0;
    void'($urandom(49));
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    // A dummy link edge lets the edge detector settle before real traffic.
    i_tx.xfer(1'b0, 32'h0, 1'b0, 8'h00);
    foreach (rst_tbl[i]) chk_reg(rst_tbl[i][39:32], rst_tbl[i][31:0]);
    $display("test reset finished");
    for (int t = 1; t < 8; t++) begin
      set_fifo(t[2:0], CTRL_RUN);
      chk_reg(ADDR_FIFO_CTRL, {25'h0, t[2:0], 4'h0});
      chk_reg(ADDR_FILL, 32'h0);
      repeat (2 * t - 1) push($urandom);
      chk_reg(ADDR_STATUS, 32'h0);
      push($urandom);
      chk_reg(ADDR_FILL, trig_level(t));
      chk_reg(ADDR_STATUS, 32'h4);
      check({31'h0, level_reached_request}, 32'h1);
      pop();
      wr_reg(ADDR_STATUS, 32'h0);
      chk_reg(ADDR_STATUS, 32'h0);
      check({31'h0, level_reached_request}, 32'h0);
    end
    $display("test trigger finished");
    set_fifo(3'h7, CTRL_RUN);
    repeat (5) push($urandom);
    repeat (5) pop();
    rd_reg(ADDR_WINDOW, d);
    chk_reg(ADDR_STATUS, 32'h2);
    wr_reg(ADDR_STATUS, 32'h2);
    wr_reg(ADDR_STATUS, 32'h0);
    chk_reg(ADDR_STATUS, 32'h2);
    wr_reg(ADDR_STATUS, 32'h0);
    chk_reg(ADDR_STATUS, 32'h0);
    $display("test underrun finished");
    repeat (18) push($urandom);
    chk_reg(ADDR_FILL, 32'h10);
    chk_reg(ADDR_STATUS, 32'h5);
    pop();
    push($urandom);
    chk_reg(ADDR_FILL, 32'hF);
    chk_reg(ADDR_STATUS, 32'h5);
    wr_reg(ADDR_STATUS, 32'h4);
    ovr_exp = 1'b0;
    chk_reg(ADDR_STATUS, 32'h4);
    push($urandom);
    chk_reg(ADDR_FILL, 32'h10);
    $display("test overrun finished");
    set_fifo(3'h1, CTRL_RUN);
    repeat (2) push($urandom);
    pop();
    pulse(1'b0, 1'b1);
    chk_reg(ADDR_STATUS, 32'h4);
    pulse(1'b0, 1'b0);
    chk_reg(ADDR_STATUS, 32'h0);
    push($urandom);
    pop();
    pulse(1'b1, 1'($urandom));
    chk_reg(ADDR_STATUS, 32'h0);
    $display("test transfer done finished");
    wr_reg(ADDR_RX_CTRL, 32'h0);
    wr_reg(ADDR_LINE_CODES, 32'hA1A2);
    wr_reg(ADDR_FRAME_CODES, 32'hB1B2);
    chk_reg(ADDR_LINE_CODES, 32'hA1A2);
    chk_reg(ADDR_FRAME_CODES, 32'hB1B2);
    set_fifo(3'h7, CTRL_END);
    send_code(8'hB1);
    send_code(8'hA1);
    repeat (3) push($urandom);
    send_code(8'hA2);
    chk_reg(ADDR_DU_TALLY, 32'h3);
    send_code(8'hA1);
    repeat (2) push($urandom);
    send_code(8'hB2);
    chk_reg(ADDR_LINE_TALLY, 32'h2);
    chk_reg(ADDR_DU_TALLY, 32'h2);
    chk_reg(ADDR_FILL, 32'h5);
    set_fifo(3'h7, CTRL_END);
    for (int l = 0; l < 3; l++) begin
      send_code(8'hA1);
      push($urandom);
      send_code(8'hA2);
    end
    chk_reg(ADDR_LINE_TALLY, 32'h2);
    send_code(8'hB2);
    chk_reg(ADDR_LINE_TALLY, 32'h4);
    // After an end code a word is refused until the next start code.
    i_tx.xfer(1'b1, $urandom, 1'b0, 8'h00);
    chk_reg(ADDR_FILL, 32'h3);
    $display("test tallies finished");
    close_out();
  end
endmodule
